// [pit_periodic_timer.sv]
// Purpose: periodic interrupt timer with keyboard interrupt routing
// Assumes: clock source and key pins sampled on CLK; sources well below CLK/2
// Notes:   registers sit in byte lane 0 of a classic Wishbone slave
`timescale 1ns/10ps

// Contract
// - request raised when counter reaches selected period
// - two-bit select picks rc, external, crystal clock
// - period code zero disables; else 512 to 32768
// - read-only pending latch shows awaiting request
// - request routed through keyboard logic, not directly; the code also feeds it straight to IRQ through event bit 0
// - acknowledge write clears pending and keyboard request
// - counting continues in wait and stop
// - sensitivity bit: edge and level, or edge
module pit_periodic_timer (
  // clock and reset
  input  wire logic                                  CLK,
  input  wire logic                                  RST_N,
  // wishbone slave
  input  wire logic                                  WB_CYC_I,
  input  wire logic                                  WB_STB_I,
  input  wire logic                                  WB_WE_I,
  input  wire logic [7:0]                            WB_ADR_I,
  input  wire logic [3:0]                            WB_SEL_I,
  input  wire logic [31:0]                           WB_DAT_I,
  output logic      [31:0]                           WB_DAT_O,
  output logic                                       WB_ACK_O,
  // periodic clock sources
  input  wire logic                                  RC_CLK,
  input  wire logic                                  EXT_CLK,
  input  wire logic                                  XTAL_CLK,
  // keyboard pins, active low
  input  wire logic [pit_pkg::PIT_NUM_KEYS-1:0]      KEY_N,
  // interrupts and status
  output logic                                       KBD_IRQ,
  output logic                                       IRQ,
  output logic                                       PENDING,
  output logic      [3:0]                            HIGH_DRIVE
);
  import pit_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic                 ack;
    logic [31:0]          rdata;
    logic [1:0]           clksel;
    logic [3:0]           hdrive;
    logic [3:0]           kben;
    logic [2:0]           period;
    logic                 mode;
    logic                 mask;
    logic [PIT_CNT_W-1:0] count;
    logic                 pending;
    logic                 hit;
    logic [PIT_IRQ_W-1:0] irq_stat;
    logic [PIT_IRQ_W-1:0] irq_mask;
    logic                 irq;
  } pit_state_t;

  pit_state_t st;
  pit_state_t next_st;

  // ==========================================================================
  // synchronised inputs
  localparam int NUM_IN = PIT_NUM_SRC + PIT_NUM_KEYS;

  logic [NUM_IN-1:0]       raw_in;
  logic [NUM_IN-1:0]       in_level;
  logic [NUM_IN-1:0]       in_rise;
  logic [NUM_IN-1:0]       in_fall;
  logic [PIT_NUM_KEYS-1:0] key_low;
  logic [PIT_NUM_KEYS-1:0] key_fall;

  // bus and decode helpers
  logic                    access;
  logic                    commit;
  logic                    wr;
  logic                    rd;
  logic                    ack_pulse;
  logic [31:0]             rd_word;
  logic                    src_tick;
  logic [15:0]             last;
  logic [PIT_IRQ_W-1:0]    events;
  logic [PIT_IRQ_W-1:0]    stat_clr;

  // keyboard unit results
  logic                    kbd_flag;
  logic                    kbd_irq_req;
  logic                    kbd_set_evt;

  // sources in the low bits, keys above them
  assign raw_in = {KEY_N, XTAL_CLK, EXT_CLK, RC_CLK};

  // ==========================================================================
  // one synchroniser per clock source and per key pin
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi = gi + 1) begin : g_sync
      pit_sync_edge u_sync (
        .clk   (CLK),
        .rst_n (RST_N),
        .din   (raw_in[gi]),
        .level (in_level[gi]),
        .rise  (in_rise[gi]),
        .fall  (in_fall[gi])
      );
    end
  endgenerate

  // keys are active low: a falling pin is a new request
  assign key_low  = ~in_level[NUM_IN-1:PIT_NUM_SRC];
  assign key_fall = in_fall[NUM_IN-1:PIT_NUM_SRC];

  // ==========================================================================
  // keyboard interrupt logic, fed by the pending latch as an internal key
  pit_kbd_unit u_kbd (
    .clk       (CLK),
    .rst_n     (RST_N),
    .key_low   (key_low),
    .key_fall  (key_fall),
    .key_en    (st.kben),
    .sense     (st.mode),
    .mask      (st.mask),
    .ack       (ack_pulse),
    .per_hit   (st.hit),
    .per_level (next_st.pending),
    .flag      (kbd_flag),
    .irq_req   (kbd_irq_req),
    .set_evt   (kbd_set_evt)
  );

  // ==========================================================================
  // register read multiplexer
  always_comb begin
    rd_word = 32'h0000_0000;
    case (WB_ADR_I)
      PIT_OFS_DRIVE: begin
        rd_word[PIT_DRV_CLKSEL_LSB +: 2] = st.clksel;
        rd_word[PIT_DRV_HD_LSB +: 4]     = st.hdrive;
        rd_word[PIT_DRV_PEND_BIT]        = st.pending;
      end
      PIT_OFS_KBEN: begin
        rd_word[PIT_KBEN_EN_LSB +: 4]  = st.kben;
        rd_word[PIT_KBEN_PER_LSB +: 3] = st.period;
      end
      PIT_OFS_KBSC: begin
        rd_word[PIT_KBSC_MODE_BIT] = st.mode;
        rd_word[PIT_KBSC_MASK_BIT] = st.mask;
        rd_word[PIT_KBSC_ACK_BIT]  = 1'b0;
        rd_word[PIT_KBSC_FLAG_BIT] = kbd_flag;
      end
      PIT_OFS_IRQ_STAT: begin
        rd_word[PIT_IRQ_W-1:0] = st.irq_stat;
      end
      PIT_OFS_IRQ_MASK: begin
        rd_word[PIT_IRQ_W-1:0] = st.irq_mask;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================================
  // next-state logic: bus, registers, counter, pending latch, interrupts
  always_comb begin
    next_st   = st;

    // bus handshake: ack one cycle after the request, dropped the next
    access    = WB_CYC_I & WB_STB_I;
    commit    = access & st.ack;
    wr        = commit & WB_WE_I & WB_SEL_I[0];
    rd        = commit & ~WB_WE_I;
    next_st.ack = access & ~st.ack;
    // read data stands only with ack, zero in every other cycle
    next_st.rdata = (access && !st.ack) ? rd_word : 32'h0000_0000;

    // acknowledge is a strobe only, never stored
    ack_pulse = wr && (WB_ADR_I == PIT_OFS_KBSC) && WB_DAT_I[PIT_KBSC_ACK_BIT];

    // register writes take effect at the edge that sees ack high
    if (wr) begin
      case (WB_ADR_I)
        PIT_OFS_DRIVE: begin
          next_st.clksel = WB_DAT_I[PIT_DRV_CLKSEL_LSB +: 2];
          next_st.hdrive = WB_DAT_I[PIT_DRV_HD_LSB +: 4];
        end
        PIT_OFS_KBEN: begin
          next_st.kben   = WB_DAT_I[PIT_KBEN_EN_LSB +: 4];
          next_st.period = WB_DAT_I[PIT_KBEN_PER_LSB +: 3];
        end
        PIT_OFS_KBSC: begin
          next_st.mode = WB_DAT_I[PIT_KBSC_MODE_BIT];
          next_st.mask = WB_DAT_I[PIT_KBSC_MASK_BIT];
        end
        PIT_OFS_IRQ_MASK: begin
          next_st.irq_mask = WB_DAT_I[PIT_IRQ_W-1:0];
        end
        default: begin
          next_st.irq_mask = st.irq_mask;
        end
      endcase
    end

    // clock source pick; reserved code yields no ticks
    case (st.clksel)
      PIT_SRC_RC:   src_tick = in_rise[0];
      PIT_SRC_EXT:  src_tick = in_rise[1];
      PIT_SRC_XTAL: src_tick = in_rise[2];
      default:      src_tick = 1'b0;
    endcase

    // terminal count for the chosen period, 512 doubling up to 32768
    last = (PIT_PERIOD_BASE << (st.period - 3'h1)) - 16'h0001;

    // counter: no low-power gating, it runs whenever its source ticks and the period code is not zero
    next_st.hit = 1'b0;
    if (st.period == 3'h0) begin
      next_st.count = '0;
    end else if (src_tick) begin
      if (st.count == last[PIT_CNT_W-1:0]) begin
        next_st.count = '0;
        next_st.hit   = 1'b1;
      end else begin
        next_st.count = st.count + 15'h0001;
      end
    end

    // pending latch: a new period beats a simultaneous acknowledge
    next_st.pending = next_st.hit | (st.pending & ~ack_pulse);

    // sticky event bits, cleared by reading them; a new event wins
    events   = '0;
    events[PIT_IRQ_PER_BIT] = st.hit;
    events[PIT_IRQ_KBD_BIT] = kbd_set_evt;
    stat_clr = (rd && (WB_ADR_I == PIT_OFS_IRQ_STAT)) ? st.irq_stat : '0;
    next_st.irq_stat = (st.irq_stat & ~stat_clr) | events;
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
  end

  // ==========================================================================
  // state register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st          <= '0;
      st.clksel   <= PIT_RST_CLKSEL;
      st.hdrive   <= PIT_RST_HD;
      st.kben     <= PIT_RST_KBEN;
      st.period   <= PIT_RST_PERIOD;
      st.mode     <= PIT_RST_MODE;
      st.mask     <= PIT_RST_MASK;
      st.irq_mask <= PIT_RST_IRQ_MASK;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs, all straight from flops
  assign WB_DAT_O   = st.rdata;
  assign WB_ACK_O   = st.ack;
  assign PENDING    = st.pending;
  assign HIGH_DRIVE = st.hdrive;
  assign IRQ        = st.irq;
  assign KBD_IRQ    = kbd_irq_req;

endmodule : pit_periodic_timer

// [pit_pkg.sv]
// Purpose: shared constants of the periodic interrupt timer block
// Assumes: registers sit in byte lane 0 of a 32-bit classic Wishbone word
// Notes:   offsets, field positions, reset values and counts live here only
package pit_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] PIT_OFS_DRIVE    = 8'h00; // port b drive control
  localparam logic [7:0] PIT_OFS_KBEN     = 8'h04; // keyboard enable register
  localparam logic [7:0] PIT_OFS_KBSC     = 8'h08; // keyboard status control
  localparam logic [7:0] PIT_OFS_IRQ_STAT = 8'h0c; // sticky event status
  localparam logic [7:0] PIT_OFS_IRQ_MASK = 8'h10; // event mask

  // ==========================================================================
  // field positions
  localparam int PIT_DRV_CLKSEL_LSB = 0;  // periodic_clock_select [1:0]
  localparam int PIT_DRV_HD_LSB     = 2;  // high current drive enables [5:2]
  localparam int PIT_DRV_PEND_BIT   = 7;  // periodic_pending_latch, read only
  localparam int PIT_KBEN_EN_LSB    = 0;  // keyboard_input_enables [3:0]
  localparam int PIT_KBEN_PER_LSB   = 4;  // periodic_period_select [6:4]
  localparam int PIT_KBSC_MODE_BIT  = 0;  // keyboard_sensitivity
  localparam int PIT_KBSC_MASK_BIT  = 1;  // keyboard_interrupt_mask
  localparam int PIT_KBSC_ACK_BIT   = 2;  // keyboard_acknowledge, write only
  localparam int PIT_KBSC_FLAG_BIT  = 3;  // keyboard_flag, read only
  localparam int PIT_IRQ_PER_BIT    = 0;  // periodic request event
  localparam int PIT_IRQ_KBD_BIT    = 1;  // keyboard request event

  // ==========================================================================
  // widths
  localparam int PIT_NUM_KEYS = 4;
  localparam int PIT_NUM_SRC  = 3;
  localparam int PIT_IRQ_W    = 2;
  localparam int PIT_CNT_W    = 15;

  // ==========================================================================
  // reset values
  localparam logic [1:0]           PIT_RST_CLKSEL   = 2'h0;
  localparam logic [3:0]           PIT_RST_HD       = 4'h0;
  localparam logic [3:0]           PIT_RST_KBEN     = 4'h0;
  localparam logic [2:0]           PIT_RST_PERIOD   = 3'h0;
  localparam logic                 PIT_RST_MODE     = 1'b0;
  localparam logic                 PIT_RST_MASK     = 1'b0;
  localparam logic [PIT_IRQ_W-1:0] PIT_RST_IRQ_MASK = 2'h0;

  // ==========================================================================
  // clock source codes and period base
  localparam logic [1:0]  PIT_SRC_RC     = 2'h0; // internal rc clock
  localparam logic [1:0]  PIT_SRC_EXT    = 2'h1; // external clock pin
  localparam logic [1:0]  PIT_SRC_XTAL   = 2'h2; // crystal reference clock
  localparam logic [15:0] PIT_PERIOD_BASE = 16'h0200; // 512 counts at code 001

endpackage : pit_pkg

// [pit_sync_edge.sv]
// Purpose: two-flop synchroniser with edge detection for one input
// Assumes: input may change at any time relative to CLK
// Notes:   the first flop feeds only the second flop
`timescale 1ns/10ps
module pit_sync_edge (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // input and its synchronised views
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } pit_sync_t;

  pit_sync_t st;
  pit_sync_t next_st;

  // ==========================================================================
  // shift chain
  always_comb begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // edges seen only past the second flop
  assign level = st.s2;
  assign rise  = st.s2 & ~st.s3;
  assign fall  = ~st.s2 & st.s3;

endmodule : pit_sync_edge

// [pit_kbd_unit.sv]
// Purpose: keyboard interrupt request logic shared with the periodic request
// Assumes: key levels and edges arrive already synchronised
// Notes:   the periodic request acts as one more internal key
`timescale 1ns/10ps
module pit_kbd_unit (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // key inputs
  input  wire logic [pit_pkg::PIT_NUM_KEYS-1:0] key_low,
  input  wire logic [pit_pkg::PIT_NUM_KEYS-1:0] key_fall,
  input  wire logic [pit_pkg::PIT_NUM_KEYS-1:0] key_en,
  // control
  input  wire logic                      sense,
  input  wire logic                      mask,
  input  wire logic                      ack,
  // periodic request
  input  wire logic                      per_hit,
  input  wire logic                      per_level,
  // results
  output logic                           flag,
  output logic                           irq_req,
  output logic                           set_evt
);
  import pit_pkg::*;

  typedef struct packed {
    logic flag;
    logic irq_req;
    logic set_evt;
  } pit_kbd_t;

  pit_kbd_t st;
  pit_kbd_t next_st;
  logic     edge_set;
  logic     level_hold;

  // ==========================================================================
  // request flag: edge sets, level holds when sensitivity is edge and level
  always_comb begin
    next_st         = st;
    edge_set        = (|(key_fall & key_en)) | per_hit;
    level_hold      = sense & ((|(key_low & key_en)) | per_level);
    next_st.set_evt = edge_set;
    next_st.flag    = edge_set | level_hold | (st.flag & ~ack);
    next_st.irq_req = next_st.flag & ~mask;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag    = st.flag;
  assign irq_req = st.irq_req;
  assign set_evt = st.set_evt;

endmodule : pit_kbd_unit

// [pit_periodic_timer_props.sv]
// Purpose: concurrent checks on the bus and pending outputs of the timer
// Assumes: one clock domain, reset asynchronous and active low
// Notes:   bound to the top module from the testbench top file
`timescale 1ns/10ps
module pit_periodic_timer_props
  import pit_pkg::*;
(
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // wishbone slave side
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  // status
  input wire logic        PENDING
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // ==========================================================================
  // acknowledge write committing at this edge
  wire ack_commit = WB_ACK_O && WB_WE_I && WB_SEL_I[0] && (WB_ADR_I == PIT_OFS_KBSC) && WB_DAT_I[PIT_KBSC_ACK_BIT];

  // bus request and its one-cycle answer
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ans;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  sequence s_ack_commit;
    ack_commit;
  endsequence

  property p_ack_lat;    s_req |=> s_ans; endproperty
  property p_ack_pulse;  WB_ACK_O |=> !WB_ACK_O; endproperty
  property p_ack_cause;  WB_ACK_O |-> $past(WB_STB_I); endproperty
  property p_dat_idle;   !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
  property p_dat_upper;  WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0; endproperty
  property p_ack_reads0;
    WB_ACK_O && !WB_WE_I && WB_ADR_I == PIT_OFS_KBSC |-> !WB_DAT_O[PIT_KBSC_ACK_BIT];
  endproperty
  property p_ack_clear;  s_ack_commit |-> ##[1:2] !PENDING; endproperty
  property p_pend_hold;
    PENDING && !ack_commit && !$past(ack_commit) |=> PENDING;
  endproperty

  a_ack_lat:    assert property (p_ack_lat) else $error("ack not one cycle after request");
  a_ack_pulse:  assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_cause:  assert property (p_ack_cause) else $error("ack without request");
  a_dat_idle:   assert property (p_dat_idle) else $error("read data not zero when idle");
  a_dat_upper:  assert property (p_dat_upper) else $error("upper read data not zero");
  a_ack_reads0: assert property (p_ack_reads0) else $error("acknowledge bit read as one");
  a_ack_clear:  assert property (p_ack_clear) else $error("acknowledge did not clear pending");
  a_pend_hold:  assert property (p_pend_hold) else $error("pending dropped without acknowledge");
endmodule : pit_periodic_timer_props

// [pit_src_model.sv]
// Purpose: counter clock sources seen by the timer
// Assumes: one source line toggles at a time, the others stay low
// Notes:   four bus cycles per source period
`timescale 1ns/10ps
module pit_src_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control from the bench
  input  wire logic [1:0] sel,
  input  wire logic       run,
  // source lines and edge count
  output logic            rc_clk,
  output logic            ext_clk,
  output logic            xtal_clk,
  output int              edges
);
  logic [1:0] ph;

  // phase runs on to zero so a stopped source always rests low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 2'h0;
      edges <= 0;
    end else if (run || ph != 2'h0) begin
      ph <= ph + 2'h1;
      if (ph == 2'h1) begin
        edges <= edges + 1;
      end
    end
  end

  // only the selected line moves
  assign rc_clk   = ph[1] && (sel == 2'h0);
  assign ext_clk  = ph[1] && (sel == 2'h1);
  assign xtal_clk = ph[1] && (sel == 2'h2);
endmodule : pit_src_model

// [tb_pit_periodic_timer.sv]
// Purpose: self-checking bench for the periodic interrupt timer
// Assumes: keys idle high, byte lane 0 always enabled
// Notes:   periods checked one edge short and exactly on the count
`timescale 1ns/10ps
module tb_pit_periodic_timer;
  import pit_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [1:0]  src_sel = 2'h0;
  logic        run = 1'b0;
  logic [3:0]  keys = 4'hf;
  logic [31:0] rdat, dat_o;
  logic        ack, rc, ext, xtal, kbd_irq, irq, pend;
  logic [3:0]  hd;
  int          src_edges;
  int          n_mismatch = 0;
  int          checks = 0;

  // ==========================================================================
  // clock, reset, instances
  always #5 clk = ~clk;
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
  end
  pit_periodic_timer dut (
    .CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .RC_CLK(rc), .EXT_CLK(ext),
    .XTAL_CLK(xtal), .KEY_N(keys), .KBD_IRQ(kbd_irq), .IRQ(irq), .PENDING(pend), .HIGH_DRIVE(hd));
  pit_src_model u_src (
    .clk(clk), .rst_n(rst_n), .sel(src_sel), .run(run), .rc_clk(rc), .ext_clk(ext),
    .xtal_clk(xtal), .edges(src_edges));

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    if (n >= 50) n_mismatch++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : wb

  task automatic run_edges(input int n);
    int t0;
    t0 = src_edges;
    run <= 1'b1;
    while (src_edges < t0 + n) @(posedge clk);
    run <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : run_edges

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 8'(i * 4), 8'h00);
      chk(rdat, 32'h0);
    end
    wb(1'b1, PIT_OFS_KBSC, 8'h07);
    wb(1'b0, PIT_OFS_KBSC, 8'h00);
    chk(rdat, 32'h3);
    wb(1'b1, PIT_OFS_KBSC, 8'h00);
    wb(1'b1, 8'h14, 8'hff);
    wb(1'b0, 8'h14, 8'h00);
    chk(rdat, 32'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_period(input logic [1:0] sel, input logic [2:0] code);
    int per;
    per = 512 << (code - 3'h1);
    src_sel <= sel;
    wb(1'b1, PIT_OFS_DRIVE, {6'h0, sel});
    wb(1'b1, PIT_OFS_KBEN, {1'b0, code, 4'h0});
    run_edges(per - 1);
    chk(32'(pend), 32'h0);
    run_edges(1);
    chk(32'(pend), 32'h1);
    chk(32'(kbd_irq), 32'h1);
    chk(32'(irq), 32'h1);
    wb(1'b0, PIT_OFS_DRIVE, 8'h00);
    chk(rdat, {24'h0, 1'b1, 5'h0, sel});
    chk(32'(rdat[PIT_DRV_PEND_BIT]), 32'h1);
    wb(1'b0, PIT_OFS_IRQ_STAT, 8'h00);
    chk(32'(rdat[PIT_IRQ_PER_BIT]), 32'h1);
    chk(32'(irq), 32'h0);
    run_edges(per);
    chk(32'(pend), 32'h1);
    wb(1'b1, PIT_OFS_KBSC, 8'h04);
    chk(32'(pend), 32'h0);
    chk(32'(kbd_irq), 32'h0);
    wb(1'b0, PIT_OFS_IRQ_STAT, 8'h00);
    $display("test period done");
  endtask : t_period

  task automatic t_off();
    src_sel <= 2'h0;
    wb(1'b1, PIT_OFS_IRQ_MASK, 8'h00);
    wb(1'b1, PIT_OFS_KBSC, 8'h02);
    wb(1'b1, PIT_OFS_DRIVE, 8'h00);
    wb(1'b1, PIT_OFS_KBEN, 8'h10);
    run_edges(512);
    chk(32'(pend), 32'h1);
    chk(32'(kbd_irq), 32'h0);
    chk(32'(irq), 32'h0);
    wb(1'b1, PIT_OFS_KBSC, 8'h04);
    wb(1'b0, PIT_OFS_IRQ_STAT, 8'h00);
    wb(1'b1, PIT_OFS_KBEN, 8'h00);
    run_edges(600);
    chk(32'(pend), 32'h0);
    wb(1'b1, PIT_OFS_KBEN, 8'h10);
    wb(1'b1, PIT_OFS_DRIVE, 8'h3f);
    chk(32'(hd), 32'hf);
    // rc line keeps toggling while the reserved code must ignore it
    src_sel <= 2'h0;
    run_edges(600);
    chk(32'(pend), 32'h0);
    $display("test off done");
  endtask : t_off

  // key 0 request, edge only and then edge and level
  task automatic t_keys();
    wb(1'b1, PIT_OFS_KBSC, 8'h00);
    wb(1'b1, PIT_OFS_KBEN, 8'h01);
    keys <= 4'he;
    repeat (8) @(posedge clk);
    chk(32'(kbd_irq), 32'h1);
    wb(1'b1, PIT_OFS_KBSC, 8'h04);
    chk(32'(kbd_irq), 32'h0);
    // software picks edge and level while keys share the request
    wb(1'b1, PIT_OFS_KBSC, 8'h05);
    chk(32'(kbd_irq), 32'h1);
    // low key disabled by software, then acknowledged
    wb(1'b1, PIT_OFS_KBEN, 8'h00);
    keys <= 4'hf;
    wb(1'b1, PIT_OFS_KBSC, 8'h04);
    chk(32'(kbd_irq), 32'h0);
    wb(1'b0, PIT_OFS_IRQ_STAT, 8'h00);
    $display("test keys done");
  endtask : t_keys

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (13) @(posedge clk);
    t_regs();
    wb(1'b1, PIT_OFS_IRQ_MASK, 8'h01);
    t_period(2'h0, 3'h1);
    t_period(2'h1, 3'h1);
    t_period(2'h2, 3'h2);
    t_keys();
    t_off();
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
endmodule : tb_pit_periodic_timer

bind pit_periodic_timer pit_periodic_timer_props u_props (
  .CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .PENDING(PENDING));
